// file: hdl/bus_arb_regs.svh
// Constants for the local bus arbiter with halt and shutdown signalling.
// Notes on behaviour
// - Locked transfers win the bus first.
// - Odd-word second byte ranks second.
// - External hold request ranks third.
// - Coprocessor operand transfers rank fourth.
// - Execution-unit data transfers rank fifth.
// - Prefetch lowest; inhibited ahead of data transfers.
// - Halt instruction halts; multiple exceptions shut down.
// - Halt cycle: status low, memory select high.
// - Address bit one: high halt, low shutdown.
// - Halted device still serves coprocessor and hold.
// - Coprocessor overrun in shutdown stops coprocessor service.
// - Non-maskable interrupt or reset leaves both.
// - Enabled interrupt or overrun also leaves halt.
// - Next address presented during current data phase.
// - Code and memory status let decoders classify.
// - Processor clock is half the input clock.
// - Descriptor table accesses assert bus lock.
// - Lock may drop between multi-operand transfers.
// - One idle state after write before hold.
// - No hold until second acknowledge ends.
// - Prefetch only with two queue bytes free.
// - Lock inactive during last locked cycle.
`ifndef BUS_ARB_REGS_SVH
`define BUS_ARB_REGS_SVH
`define STAT_IDLE 2'h3
`define STAT_READ 2'h1
`define STAT_WRITE 2'h2
`define STAT_HALT 2'h0
`define STAT_INTA 2'h0
`define QUEUE_MIN_FREE 3'h2
`define SYS_CLK_PERIOD_NS 10
`define PROC_CLK_PERIOD_NS 20
`define PROC_CLK_DIV (`PROC_CLK_PERIOD_NS / `SYS_CLK_PERIOD_NS)
`endif

// file: hdl/bus_arb_pkg.sv
// Types shared by the local bus arbiter.
package bus_arb_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_SEND, ST_CMD, ST_WIDLE, ST_HOLD, ST_HALTOP} state_t;
  typedef enum logic [1:0] {MODE_RUN, MODE_HALT, MODE_SHUT} mode_t;
  typedef enum logic [2:0] {
    SRC_NONE, SRC_LOCK, SRC_SPLIT, SRC_HOLD, SRC_COPROC, SRC_EU, SRC_PREF
  } src_t;
  typedef struct packed {
    logic status_bit_one;
    logic status_bit_zero;
    logic code_or_intack_status;
    logic mem_io;
    logic addr_bit_one;
  } bus_status_t;
endpackage : bus_arb_pkg

// file: hdl/cpu_local_bus_priority_halt.sv
// Local bus arbiter with pipelined status and halt or shutdown cycles.
`timescale 1ns/1ps
`include "bus_arb_regs.svh"
module cpu_local_bus_priority_halt
  import bus_arb_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Internal requesters.
  input wire logic lock_req_i,
  input wire logic desc_access_i,
  input wire logic intack_req_i,
  input wire logic lock_last_i,
  input wire logic eu_req_i,
  input wire logic eu_soon_i,
  input wire logic [2:0] queue_free_i,
  input wire logic op_write_i,
  input wire logic op_io_i,
  input wire logic op_odd_word_i,
  // External requesters and bus completion.
  input wire logic hold_i,
  input wire logic coproc_operand_request_i,
  input wire logic ready_i,
  // Halt, shutdown and their exits.
  input wire logic halt_instruction_i,
  input wire logic multi_exception_i,
  input wire logic nmi_i,
  input wire logic maskable_irq_request_i,
  input wire logic irq_enable_i,
  input wire logic coproc_overrun_i,
  // Bus status pins.
  output logic status_bit_one_o,
  output logic status_bit_zero_o,
  output logic code_or_intack_status_o,
  output logic mem_io_o,
  output logic addr_bit_one_o,
  output logic lock_n_o,
  output logic bus_grant_ack_o,
  // Arbiter state.
  output src_t bus_src_o,
  output src_t next_src_o,
  output logic proc_clk_o,
  output logic halted_o,
  output logic shutdown_o
);

  logic ph_r, ph_nxt;
  state_t state_r, state_nxt;
  mode_t mode_r, mode_nxt;
  src_t src_r, src_nxt, next_r, next_nxt, pick;
  bus_status_t stat_r, stat_nxt;
  logic lock_n_r, lock_n_nxt, grant_r, grant_nxt;
  logic wr_r, wr_nxt, odd_r, odd_nxt, inta_r, inta_nxt;
  logic split_r, split_nxt, inta_second_r, inta_second_nxt;
  logic last_lock_r, last_lock_nxt, halt_pend_r, halt_pend_nxt;
  logic coproc_stop_r, coproc_stop_nxt;
  logic tick, run;

  // The processor clock is the input clock divided by two.
  always_comb begin
    ph_nxt = ~ph_r;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ph_r <= 1'b0;
    end else begin
      ph_r <= ph_nxt;
    end
  end

  assign tick = ph_r;
  assign run = (mode_r == MODE_RUN);

  // Halt and shutdown mode; reset leaves both through the synchronous reset.
  always_comb begin
    mode_nxt = mode_r;
    halt_pend_nxt = halt_pend_r;
    coproc_stop_nxt = coproc_stop_r;
    case (mode_r)
      MODE_RUN: begin
        if (multi_exception_i) begin
          mode_nxt = MODE_SHUT;
          halt_pend_nxt = 1'b1;
        end else if (halt_instruction_i) begin
          mode_nxt = MODE_HALT;
          halt_pend_nxt = 1'b1;
        end
      end
      MODE_HALT: begin
        if (nmi_i || (maskable_irq_request_i && irq_enable_i) || coproc_overrun_i) begin
          mode_nxt = MODE_RUN;
        end
      end
      default: begin
        if (nmi_i) begin
          mode_nxt = MODE_RUN;
          coproc_stop_nxt = 1'b0;
        end else if (coproc_overrun_i) begin
          coproc_stop_nxt = 1'b1;
        end
      end
    endcase
    if (tick && state_r == ST_HALTOP) begin
      halt_pend_nxt = 1'b0;
    end
    if (mode_nxt == MODE_RUN) begin
      halt_pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mode_r <= MODE_RUN;
      halt_pend_r <= 1'b0;
      coproc_stop_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      halt_pend_r <= halt_pend_nxt;
      coproc_stop_r <= coproc_stop_nxt;
    end
  end

  // Fixed priority pick; only the halted set of requesters runs while stopped.
  always_comb begin
    if (run && (lock_req_i || desc_access_i || intack_req_i)) begin
      pick = SRC_LOCK;
    end else if (split_r) begin
      pick = SRC_SPLIT;
    end else if (hold_i && !inta_second_r) begin
      pick = SRC_HOLD;
    end else if (coproc_operand_request_i && !coproc_stop_r) begin
      pick = SRC_COPROC;
    end else if (run && eu_req_i) begin
      pick = SRC_EU;
    end else if (run && !eu_soon_i && queue_free_i >= `QUEUE_MIN_FREE) begin
      pick = SRC_PREF;
    end else begin
      pick = SRC_NONE;
    end
  end

  // Bus sequencer; it moves only on processor clock edges and picks only at
  // operation boundaries, so a late high-priority request never cuts in.
  always_comb begin
    state_nxt = state_r;
    src_nxt = src_r;
    next_nxt = next_r;
    stat_nxt = stat_r;
    lock_n_nxt = lock_n_r;
    grant_nxt = grant_r;
    wr_nxt = wr_r;
    odd_nxt = odd_r;
    inta_nxt = inta_r;
    split_nxt = split_r;
    inta_second_nxt = inta_second_r;
    last_lock_nxt = last_lock_r;
    if (tick) begin
      case (state_r)
        ST_IDLE: begin
          stat_nxt = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
          src_nxt = SRC_NONE;
          if (halt_pend_r && !split_r) begin
            state_nxt = ST_HALTOP;
            stat_nxt = '{1'b0, 1'b0, 1'b0, 1'b1, mode_r == MODE_HALT};
          end else if (pick == SRC_HOLD) begin
            state_nxt = ST_HOLD;
            grant_nxt = 1'b1;
            src_nxt = SRC_HOLD;
          end else if (pick != SRC_NONE) begin
            state_nxt = ST_SEND;
          end
        end
        ST_SEND: begin
          state_nxt = ST_CMD;
          stat_nxt.status_bit_one = 1'(`STAT_IDLE >> 1);
          stat_nxt.status_bit_zero = 1'(`STAT_IDLE & 2'h1);
        end
        ST_CMD: begin
          lock_n_nxt = 1'b1;
          next_nxt = pick;
          if (ready_i) begin
            if (inta_r) begin
              inta_second_nxt = ~inta_second_r;
            end
            if (src_r == SRC_SPLIT) begin
              split_nxt = 1'b0;
            end else if (odd_r) begin
              split_nxt = 1'b1;
            end
            if (pick == SRC_HOLD && !split_nxt && !(inta_r && !inta_second_r)) begin
              state_nxt = wr_r ? ST_WIDLE : ST_HOLD;
              grant_nxt = !wr_r;
              // The holder is shown as the source only once the grant is given.
              src_nxt = wr_r ? src_r : SRC_HOLD;
            end else begin
              state_nxt = ST_IDLE;
            end
            next_nxt = SRC_NONE;
          end
        end
        ST_WIDLE: begin
          state_nxt = ST_HOLD;
          grant_nxt = 1'b1;
          src_nxt = SRC_HOLD;
        end
        ST_HOLD: begin
          if (!hold_i) begin
            state_nxt = ST_IDLE;
            grant_nxt = 1'b0;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
          stat_nxt = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        end
      endcase
      // Launching an operation loads its class onto the status pins.
      if (state_r == ST_IDLE && state_nxt == ST_SEND) begin
        src_nxt = pick;
        inta_nxt = (pick == SRC_LOCK) && intack_req_i;
        wr_nxt = (pick == SRC_SPLIT) ? wr_r : (op_write_i && pick != SRC_PREF && !inta_nxt);
        odd_nxt = (pick != SRC_SPLIT) && (pick != SRC_PREF) && op_odd_word_i && !inta_nxt;
        last_lock_nxt = (pick == SRC_LOCK) && lock_last_i && !intack_req_i;
        lock_n_nxt = !((pick == SRC_LOCK) && (intack_req_i || !lock_last_i));
        if (inta_nxt) begin
          stat_nxt = '{1'(`STAT_INTA >> 1), 1'(`STAT_INTA & 2'h1), 1'b0, 1'b0, 1'b0};
        end else if (pick == SRC_PREF) begin
          stat_nxt = '{1'(`STAT_READ >> 1), 1'(`STAT_READ & 2'h1), 1'b1, 1'b1, 1'b0};
        end else if (wr_nxt) begin
          stat_nxt = '{1'(`STAT_WRITE >> 1), 1'(`STAT_WRITE & 2'h1), 1'b0, !op_io_i, 1'b0};
        end else begin
          stat_nxt = '{1'(`STAT_READ >> 1), 1'(`STAT_READ & 2'h1), 1'b0, !op_io_i, 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_r <= ST_IDLE;
      src_r <= SRC_NONE;
      next_r <= SRC_NONE;
      stat_r <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      lock_n_r <= 1'b1;
      grant_r <= 1'b0;
      wr_r <= 1'b0;
      odd_r <= 1'b0;
      inta_r <= 1'b0;
      split_r <= 1'b0;
      inta_second_r <= 1'b0;
      last_lock_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      src_r <= src_nxt;
      next_r <= next_nxt;
      stat_r <= stat_nxt;
      lock_n_r <= lock_n_nxt;
      grant_r <= grant_nxt;
      wr_r <= wr_nxt;
      odd_r <= odd_nxt;
      inta_r <= inta_nxt;
      split_r <= split_nxt;
      inta_second_r <= inta_second_nxt;
      last_lock_r <= last_lock_nxt;
    end
  end

  // Every output is a flip-flop except halted_o and shutdown_o, which are decoded from mode_r.
  assign status_bit_one_o = stat_r.status_bit_one;
  assign status_bit_zero_o = stat_r.status_bit_zero;
  assign code_or_intack_status_o = stat_r.code_or_intack_status;
  assign mem_io_o = stat_r.mem_io;
  assign addr_bit_one_o = stat_r.addr_bit_one;
  assign lock_n_o = lock_n_r;
  assign bus_grant_ack_o = grant_r;
  assign bus_src_o = src_r;
  assign next_src_o = next_r;
  assign proc_clk_o = ph_r;
  assign halted_o = (mode_r == MODE_HALT);
  assign shutdown_o = (mode_r == MODE_SHUT);

  // Checks on the sequencer.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_halt_pattern;
    (state_r == ST_HALTOP) |-> !status_bit_one_o && !status_bit_zero_o
      && !code_or_intack_status_o && mem_io_o;
  endproperty
  a_halt_pattern: assert property (p_halt_pattern) else $error("bad halt status");

  property p_halt_a1;
    (state_r == ST_HALTOP) |-> addr_bit_one_o == (mode_r == MODE_HALT);
  endproperty
  a_halt_a1: assert property (p_halt_a1) else $error("bad halt address bit");

  property p_clk_div;
    proc_clk_o |=> !proc_clk_o ##1 proc_clk_o;
  endproperty
  a_clk_div: assert property (p_clk_div) else $error("processor clock not halved");

  property p_write_idle;
    (state_r == ST_CMD && tick && ready_i && wr_r && state_nxt != ST_IDLE) |=>
      state_r == ST_WIDLE && !bus_grant_ack_o ##2 bus_grant_ack_o;
  endproperty
  a_write_idle: assert property (p_write_idle) else $error("no idle after write");

  property p_no_coproc;
    (state_r == ST_IDLE && $past(coproc_stop_r) && coproc_stop_r) ##1 (state_r == ST_SEND)
      |-> src_r != SRC_COPROC;
  endproperty
  a_no_coproc: assert property (p_no_coproc) else $error("coprocessor served");

  property p_nmi_exit;
    (nmi_i && mode_r != MODE_RUN) |=> halted_o == 1'b0 && shutdown_o == 1'b0;
  endproperty
  a_nmi_exit: assert property (p_nmi_exit) else $error("nmi did not exit");

  property p_shut_stays;
    (mode_r == MODE_SHUT && !nmi_i) |=> shutdown_o;
  endproperty
  a_shut_stays: assert property (p_shut_stays) else $error("shutdown left");

  property p_last_lock;
    (state_r == ST_SEND && last_lock_r) |-> lock_n_o;
  endproperty
  a_last_lock: assert property (p_last_lock) else $error("lock on last cycle");

  property p_inta_hold;
    inta_second_r |-> !bus_grant_ack_o;
  endproperty
  a_inta_hold: assert property (p_inta_hold) else $error("hold between acknowledges");

  property p_lock_first;
    (state_r == ST_IDLE && tick && run && lock_req_i && !halt_pend_r) |=> src_r != SRC_EU
      && src_r != SRC_PREF && src_r != SRC_COPROC;
  endproperty
  a_lock_first: assert property (p_lock_first) else $error("lock lost priority");

  c_halt_op: cover property (state_r == ST_HALTOP && mode_r == MODE_HALT);
  c_shut_op: cover property (state_r == ST_HALTOP && mode_r == MODE_SHUT);
  c_hold: cover property ($rose(bus_grant_ack_o));
  c_split: cover property (state_r == ST_SEND && src_r == SRC_SPLIT);

endmodule : cpu_local_bus_priority_halt

// file: testbench/bus_ctrl_model.sv
// Bus controller model that answers ready after the command delay.
`timescale 1ns/1ps
module bus_ctrl_model (
  // Clock and observed bus status.
  input wire logic clk_i,
  input wire logic proc_clk_i,
  input wire logic [1:0] status_i,
  input wire logic mem_io_i,
  // Extra wait ticks, and ready back to the processor.
  input wire logic [1:0] wait_i,
  output logic ready_o
);
  logic busy_r = 1'h0;
  logic [2:0] cnt_r = 3'h0;

  initial begin
    ready_o = 1'h0;
  end

  // Ready moves on falling edges only, so it is settled at each tick edge.
  // It drops after one tick, so no later command state sees a stale answer.
  always @(negedge clk_i) begin
    if (!proc_clk_i) begin
      ready_o <= 1'h0;
    end else if (busy_r) begin
      if (cnt_r == 3'h0) begin
        ready_o <= 1'h1;
        busy_r <= 1'h0;
      end else begin
        cnt_r <= cnt_r - 3'h1;
      end
    end else if (status_i != 2'h3 && !(status_i == 2'h0 && mem_io_i)) begin
      busy_r <= 1'h1;
      cnt_r <= {1'h0, wait_i} + 3'h1;
    end
  end
endmodule : bus_ctrl_model

// file: testbench/cpu_local_bus_priority_halt_tb.sv
// Self-checking bench for the local bus arbiter with halt and shutdown.
`timescale 1ns/1ps
module cpu_local_bus_priority_halt_tb;
  import bus_arb_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic lreq = 1'h0, desc = 1'h0, inta = 1'h0, llast = 1'h0, eu = 1'h0, soon = 1'h0;
  logic wr = 1'h0, io = 1'h0, odd = 1'h0, hold = 1'h0, cop = 1'h0, halt_instruction = 1'h0;
  logic mexc = 1'h0, nmi = 1'h0, irq = 1'h0, ien = 1'h0, ovr = 1'h0, rdy;
  logic [2:0] qf = 3'h0;
  logic [1:0] slow = 2'h0;
  logic s1, s0, cod, mio, a1, lock_n, gnt, pclk, halted, shut;
  src_t src, nsrc;
  int errors = 0;
  int checks_done = 0;

  // A half period of 5 ns gives the 100 MHz system clock.
  always #5 clk = ~clk;

  cpu_local_bus_priority_halt i_dut (
    .clk_i(clk), .reset_n_i(rst_n), .lock_req_i(lreq), .desc_access_i(desc),
    .intack_req_i(inta), .lock_last_i(llast), .eu_req_i(eu), .eu_soon_i(soon),
    .queue_free_i(qf), .op_write_i(wr), .op_io_i(io), .op_odd_word_i(odd), .hold_i(hold),
    .coproc_operand_request_i(cop), .ready_i(rdy), .halt_instruction_i(halt_instruction),
    .multi_exception_i(mexc), .nmi_i(nmi), .maskable_irq_request_i(irq),
    .irq_enable_i(ien), .coproc_overrun_i(ovr), .status_bit_one_o(s1),
    .status_bit_zero_o(s0), .code_or_intack_status_o(cod), .mem_io_o(mio),
    .addr_bit_one_o(a1), .lock_n_o(lock_n), .bus_grant_ack_o(gnt), .bus_src_o(src),
    .next_src_o(nsrc), .proc_clk_o(pclk), .halted_o(halted), .shutdown_o(shut)
  );

  bus_ctrl_model i_ctrl (
    .clk_i(clk), .proc_clk_i(pclk), .status_i({s1, s0}), .mem_io_i(mio),
    .wait_i(slow), .ready_o(rdy)
  );

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  // Compares with case equality so that an unknown never matches.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One clock of a bounded wait; a spent bound is a mismatch and ends the run.
  task automatic tick(inout int n);
    @(negedge clk);
    n++;
    if (n > 300) begin
      chk(8'h0, 8'h1);
      wrap_up();
    end
  endtask : tick

  // Waits for the source of a new operation, then compares it.
  task automatic next_op(input src_t prev, input src_t exp);
    int n;
    n = 0;
    while (src === prev || src === SRC_NONE) tick(n);
    chk({5'h0, src}, {5'h0, exp});
  endtask : next_op

  // Waits for the status-only halt or shutdown cycle and compares its pins.
  task automatic halt_op(input logic [4:0] exp);
    int n;
    n = 0;
    while (!({s1, s0} === 2'h0 && mio === 1'h1)) tick(n);
    chk({3'h0, s1, s0, cod, mio, a1}, {3'h0, exp});
  endtask : halt_op

  // Passes only when the bus stays idle for twelve clocks in a row, long enough
  // that a command state still running cannot hide a wrongly launched operation.
  task automatic settle;
    int n;
    int q;
    n = 0;
    q = 0;
    while (q < 12) begin
      tick(n);
      q = ({s1, s0} === 2'h3 && gnt === 1'h0) ? q + 1 : 0;
    end
  endtask : settle

  // Every requester at once; each winner is withdrawn as soon as it is seen.
  task automatic t_prio;
    int n;
    n = 0;
    desc = 1'h1;
    hold = 1'h1;
    cop = 1'h1;
    eu = 1'h1;
    qf = 3'h6;
    next_op(src, SRC_LOCK);
    chk({7'h0, lock_n}, 8'h0);
    desc = 1'h0;
    next_op(SRC_LOCK, SRC_HOLD);
    hold = 1'h0;
    next_op(SRC_HOLD, SRC_COPROC);
    cop = 1'h0;
    while (nsrc === SRC_NONE) tick(n);
    chk({5'h0, nsrc}, {5'h0, SRC_EU});
    next_op(SRC_COPROC, SRC_EU);
    eu = 1'h0;
    next_op(SRC_EU, SRC_PREF);
    chk({7'h0, cod}, 8'h1);
    qf = 3'h1;
    settle();
    qf = 3'h6;
    soon = 1'h1;
    settle();
    soon = 1'h0;
    qf = 3'h0;
    $display("priority test done");
  endtask : t_prio

  // Odd word write to I/O with a slow controller; hold arrives mid-operation.
  task automatic t_split;
    slow = 2'h2;
    wr = 1'h1;
    io = 1'h1;
    odd = 1'h1;
    eu = 1'h1;
    next_op(src, SRC_EU);
    chk({4'h0, s1, s0, mio, cod}, 8'h08);
    eu = 1'h0;
    odd = 1'h0;
    io = 1'h0;
    hold = 1'h1;
    next_op(SRC_EU, SRC_SPLIT);
    chk({6'h0, s1, s0}, 8'h02);
    next_op(SRC_SPLIT, SRC_HOLD);
    hold = 1'h0;
    wr = 1'h0;
    slow = 2'h0;
    eu = 1'h1;
    next_op(SRC_HOLD, SRC_EU);
    eu = 1'h0;
    $display("split word test done");
  endtask : t_split

  // Two acknowledge operations with hold pending; hold waits for the second.
  task automatic t_inta;
    int n;
    n = 0;
    inta = 1'h1;
    hold = 1'h1;
    next_op(src, SRC_LOCK);
    chk({4'h0, s1, s0, cod, mio}, 8'h00);
    while ({s1, s0} === 2'h0) tick(n);
    while ({s1, s0} !== 2'h0) tick(n);
    inta = 1'h0;
    chk({7'h0, gnt}, 8'h0);
    while (gnt !== 1'h1) tick(n);
    chk({5'h0, src}, {5'h0, SRC_HOLD});
    hold = 1'h0;
    $display("acknowledge test done");
  endtask : t_inta

  // Halt then shutdown, with service and exits in each.
  task automatic t_halt;
    halt_instruction = 1'h1;
    @(negedge clk);
    halt_instruction = 1'h0;
    halt_op(5'h03);
    chk({7'h0, halted}, 8'h1);
    hold = 1'h1;
    next_op(src, SRC_HOLD);
    hold = 1'h0;
    irq = 1'h1;
    repeat (4) @(negedge clk);
    chk({7'h0, halted}, 8'h1);
    ien = 1'h1;
    repeat (2) @(negedge clk);
    chk({7'h0, halted}, 8'h0);
    mexc = 1'h1;
    @(negedge clk);
    mexc = 1'h0;
    halt_op(5'h02);
    chk({7'h0, shut}, 8'h1);
    repeat (4) @(negedge clk);
    chk({7'h0, shut}, 8'h1);
    irq = 1'h0;
    ien = 1'h0;
    cop = 1'h1;
    next_op(src, SRC_COPROC);
    cop = 1'h0;
    ovr = 1'h1;
    @(negedge clk);
    ovr = 1'h0;
    chk({7'h0, shut}, 8'h1);
    cop = 1'h1;
    settle();
    cop = 1'h0;
    nmi = 1'h1;
    repeat (2) @(negedge clk);
    chk({7'h0, shut}, 8'h0);
    nmi = 1'h0;
    $display("halt and shutdown test done");
  endtask : t_halt

  // Reset for 16 clocks, check the idle pins, then run the scenarios.
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'h1;
    @(negedge clk);
    chk({2'h0, s1, s0, lock_n, gnt, halted, shut}, 8'h38);
    t_prio();
    t_split();
    t_inta();
    t_halt();
    wrap_up();
  end
endmodule : cpu_local_bus_priority_halt_tb
